// >>> shared/status_pg_defines.svh
// constants for the status aggregation and power-good block
`ifndef STATUS_PG_DEFINES_SVH
`define STATUS_PG_DEFINES_SVH

// ----------------------------------------
// command codes
// ----------------------------------------
`define CMD_ALL_STATUS 8'hDB
`define CMD_PHASE_SUMMARY 8'hDC
`define CMD_PG_CONFIG 8'hE3

// ----------------------------------------
// phase selector values
// ----------------------------------------
`define PHASE_ALL 8'hFF
`define PHASE_ALL_ALT 8'h80
`define PHASE_NUM 4

// ----------------------------------------
// snapshot byte lanes
// ----------------------------------------
`define SNAP_MFR_HI 55
`define SNAP_MFR_LO 48
`define SNAP_OTHER_LO 40
`define SNAP_CML_HI 39
`define SNAP_CML_LO 32
`define SNAP_TEMP_LO 24
`define SNAP_INPUT_LO 16
`define SNAP_IOUT_LO 8
`define SNAP_VOUT_LO 0
`define CML_INVALID_BIT 7

// ----------------------------------------
// power-good configuration fields
// ----------------------------------------
`define PG_FALL_HI 15
`define PG_FALL_LO 12
`define PG_RISE_HI 11
`define PG_RISE_LO 8
`define PG_MASK_HI 7
`define PG_MASK_LO 0
`define PG_CONFIG_RESET 16'h0000
`define PHASE_SUMMARY_RESET 4'h0

`endif

// >>> shared/status_pg_pkg.sv
// types for the status aggregation and power-good block
package status_pg_pkg;
   typedef logic [7:0] cmd_type;
   typedef logic [15:0] word_type;
   typedef logic [55:0] snapshot_type;
   typedef logic [15:0] delay_count_type;
   typedef enum logic [0:0] {
      pg_low_type_s = 1'b0,
      pg_high_type_s = 1'b1
   } pg_state_type;
endpackage : status_pg_pkg

// >>> hw/status_phase_and_power_good.sv
// status snapshot, phase fault summary and power-good timing
`timescale 1ns/1ps
`include "status_pg_defines.svh"
//
// What this block does
// - a read of the all-status command returns the seven live status bytes in fixed lanes.
// - a write to a read-only command sets the communication fault, the invalid command bit and the alert.
// - a write to the all-status command clears no status bit.
// - with phase selector all, the phase summary read gives one fault bit per phase.
// - with a single phase selected, bit 0 of the summary shows whether that phase reports any fault.
// - summary bits of unassigned or disabled phases and bits 15:4 read as zero.
// - summary bits 3:0 are set by a fault of the matching phase and reset to zero.
// - power-good falls after an unmasked event by one switching clock for 0 or 2^N+1 for N.
// - power-good rises after all unmasked events end by one switching clock for 0 or 2^N+1.
// - an event whose mask bit is one cannot pull power-good low.
// - the power-good configuration is read-only while conversion is enabled.
// - power-good is low while disabled, during turn-on delay and rise, turn-off fall and fault stop.
// - the fall delay is bypassed during turn-off fall and fault shutdown or hiccup.
// - an unmasked fault whose response is continue-without-interruption does not pull it low.
// - fall and rise delays are timed by independent counters.

module status_phase_and_power_good (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   input wire status_pg_pkg::cmd_type cmd_code,
   input wire status_pg_pkg::word_type cmd_wdata,
   input wire logic [7:0] phase_sel,
   input wire logic [7:0] status_mfr,
   input wire logic [7:0] status_other,
   input wire logic [7:0] status_cml,
   input wire logic [7:0] status_temp,
   input wire logic [7:0] status_input,
   input wire logic [7:0] status_iout,
   input wire logic [7:0] status_vout,
   input wire logic cml_clear,
   input wire logic [3:0] phase_fault_evt,
   input wire logic [3:0] phase_enabled,
   input wire logic [7:0] pg_events,
   input wire logic [7:0] pg_event_continue,
   input wire logic conversion_enabled,
   input wire logic seq_ton_delay,
   input wire logic seq_ton_rise,
   input wire logic seq_toff_fall,
   input wire logic seq_fault_stop,
   input wire logic pwm_tick,
   input wire status_pg_pkg::word_type nvm_pg_config,
   output status_pg_pkg::snapshot_type rd_data,
   output logic rd_valid,
   output logic invalid_command_flag,
   output logic cml_fault_flag,
   output logic alert_req,
   output logic power_good_out
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   status_pg_pkg::word_type power_good_config_q;
   logic nvm_loaded_q;
   logic [3:0] phase_fault_q;
   logic invalid_q;
   status_pg_pkg::snapshot_type rd_data_q;
   logic rd_valid_q;
   status_pg_pkg::pg_state_type pg_q;
   status_pg_pkg::delay_count_type fall_cnt_q;
   status_pg_pkg::delay_count_type rise_cnt_q;

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   wire logic hit_all = (cmd_code == `CMD_ALL_STATUS);
   wire logic hit_phase = (cmd_code == `CMD_PHASE_SUMMARY);
   wire logic hit_pg = (cmd_code == `CMD_PG_CONFIG);
   // read-only write attempts
   wire logic wr_all = cmd_wr && hit_all;
   // config locked while converting
   wire logic wr_pg_locked = cmd_wr && hit_pg && conversion_enabled;
   wire logic wr_pg_ok = cmd_wr && hit_pg && !conversion_enabled;
   wire logic wr_phase = cmd_wr && hit_phase;
   wire logic invalid_evt = wr_all || wr_pg_locked;

   // ----------------------------------------
   // all-status snapshot
   // ----------------------------------------
   wire logic [7:0] cml_live = status_cml |
      ({7'h00, invalid_q} << `CML_INVALID_BIT);
   wire status_pg_pkg::snapshot_type snapshot = {status_mfr, status_other, cml_live,
      status_temp, status_input, status_iout, status_vout};

   // ----------------------------------------
   // phase summary
   // ----------------------------------------
   wire logic [3:0] phase_visible = phase_fault_q & phase_enabled;
   wire logic all_phases = (phase_sel == `PHASE_ALL) || (phase_sel == `PHASE_ALL_ALT);
   wire logic sel_in_range = (phase_sel < 8'(`PHASE_NUM));
   wire logic sel_fault = sel_in_range && phase_visible[phase_sel[1:0]];
   wire status_pg_pkg::word_type phase_word = all_phases ? {12'h000, phase_visible} :
      {15'h0000, sel_fault};

   wire status_pg_pkg::snapshot_type rd_mux =
      hit_all ? snapshot :
      hit_phase ? {40'h00_0000_0000, phase_word} :
      hit_pg ? {40'h00_0000_0000, power_good_config_q} :
      56'h00_0000_0000_0000;

   // ----------------------------------------
   // power-good qualification
   // ----------------------------------------
   wire logic [7:0] pg_mask = power_good_config_q[`PG_MASK_HI:`PG_MASK_LO];
   wire logic [3:0] fall_sel = power_good_config_q[`PG_FALL_HI:`PG_FALL_LO];
   wire logic [3:0] rise_sel = power_good_config_q[`PG_RISE_HI:`PG_RISE_LO];
   wire logic unmasked_evt = |(pg_events & ~pg_mask & ~pg_event_continue);
   wire logic force_low = !conversion_enabled || seq_ton_delay || seq_ton_rise ||
      seq_toff_fall || seq_fault_stop;
   wire status_pg_pkg::delay_count_type fall_len = (fall_sel == 4'h0) ? 16'h0001 :
      16'((17'h0_0001 << fall_sel) + 17'h0_0001);
   wire status_pg_pkg::delay_count_type rise_len = (rise_sel == 4'h0) ? 16'h0001 :
      16'((17'h0_0001 << rise_sel) + 17'h0_0001);
   wire logic fall_done = pwm_tick && (fall_cnt_q + 16'h0001 >= fall_len);
   wire logic rise_done = pwm_tick && (rise_cnt_q + 16'h0001 >= rise_len);

   // ----------------------------------------
   // configuration register
   // ----------------------------------------
   // load from non-volatile memory
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         power_good_config_q <= `PG_CONFIG_RESET;
         nvm_loaded_q <= 1'b0;
      end else if (!nvm_loaded_q) begin
         power_good_config_q <= nvm_pg_config;
         nvm_loaded_q <= 1'b1;
      end else if (wr_pg_ok) begin
         power_good_config_q <= cmd_wdata;
      end
   end

   // ----------------------------------------
   // phase fault bits
   // ----------------------------------------
   // sticky per phase, set wins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         phase_fault_q <= `PHASE_SUMMARY_RESET;
      end else begin
         phase_fault_q <= phase_fault_evt |
            (phase_fault_q & ~(wr_phase ? cmd_wdata[3:0] : 4'h0));
      end
   end

   // ----------------------------------------
   // invalid command flag
   // ----------------------------------------
   // sticky, set wins over clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         invalid_q <= 1'b0;
      end else begin
         invalid_q <= invalid_evt || (invalid_q && !cml_clear);
      end
   end

   // ----------------------------------------
   // read answer
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_data_q <= 56'h00_0000_0000_0000;
         rd_valid_q <= 1'b0;
      end else begin
         rd_data_q <= cmd_rd ? rd_mux : rd_data_q;
         rd_valid_q <= cmd_rd;
      end
   end

   // ----------------------------------------
   // fall counter
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n || !unmasked_evt || force_low || pg_q == status_pg_pkg::pg_low_type_s) begin
         fall_cnt_q <= 16'h0000;
      end else if (pwm_tick && !fall_done) begin
         fall_cnt_q <= fall_cnt_q + 16'h0001;
      end
   end

   // ----------------------------------------
   // rise counter
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n || unmasked_evt || force_low || pg_q == status_pg_pkg::pg_high_type_s) begin
         rise_cnt_q <= 16'h0000;
      end else if (pwm_tick && !rise_done) begin
         rise_cnt_q <= rise_cnt_q + 16'h0001;
      end
   end

   // ----------------------------------------
   // power-good state
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pg_q <= status_pg_pkg::pg_low_type_s;
      end else begin
         unique case (pg_q)
            status_pg_pkg::pg_high_type_s: begin
               if (force_low || (unmasked_evt && fall_done)) begin
                  pg_q <= status_pg_pkg::pg_low_type_s;
               end
            end
            status_pg_pkg::pg_low_type_s: begin
               if (!force_low && !unmasked_evt && rise_done) begin
                  pg_q <= status_pg_pkg::pg_high_type_s;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign rd_data = rd_data_q;
   assign rd_valid = rd_valid_q;
   assign invalid_command_flag = invalid_q;
   assign cml_fault_flag = invalid_q;
   assign alert_req = invalid_q;
   assign power_good_out = (pg_q == status_pg_pkg::pg_high_type_s);

endmodule : status_phase_and_power_good

// >>> verif/status_pg_checker.sv
// port assertions for the status and power-good block
`timescale 1ns/1ps
module status_pg_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   input wire status_pg_pkg::cmd_type cmd_code,
   input wire logic [7:0] status_mfr,
   input wire logic [7:0] status_vout,
   input wire logic cml_clear,
   input wire logic conversion_enabled,
   input wire logic seq_ton_delay,
   input wire logic seq_ton_rise,
   input wire logic seq_toff_fall,
   input wire logic seq_fault_stop,
   input wire status_pg_pkg::snapshot_type rd_data,
   input wire logic rd_valid,
   input wire logic invalid_command_flag,
   input wire logic cml_fault_flag,
   input wire logic alert_req,
   input wire logic power_good_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   read_answer_a: assert property (cmd_rd |=> rd_valid)
      else $error("read not answered");
   valid_cause_a: assert property (rd_valid |-> $past(cmd_rd))
      else $error("answer without read");
   snap_lanes_a: assert property (cmd_rd && cmd_code == 8'hDB |=>
      rd_data[55:48] == $past(status_mfr) && rd_data[7:0] == $past(status_vout))
      else $error("snapshot lanes wrong");
   ro_write_a: assert property (cmd_wr && cmd_code == 8'hDB |=> invalid_command_flag)
      else $error("read-only write not flagged");
   flag_mirror_a: assert property (alert_req == invalid_command_flag &&
      cml_fault_flag == invalid_command_flag) else $error("flags differ");
   flag_clear_a: assert property ($fell(invalid_command_flag) |-> $past(cml_clear))
      else $error("flag cleared without request");
   phase_zero_a: assert property (cmd_rd && cmd_code == 8'hDC |=> rd_data[55:4] == '0)
      else $error("reserved summary bits set");
   cfg_lock_a: assert property (cmd_wr && cmd_code == 8'hE3 && conversion_enabled |=>
      alert_req) else $error("locked config write not flagged");
   pg_forced_a: assert property (!conversion_enabled || seq_ton_delay || seq_ton_rise ||
      seq_toff_fall || seq_fault_stop |=> !power_good_out) else $error("power good not forced");
endmodule : status_pg_checker
bind status_phase_and_power_good status_pg_checker u_chk (
   .clk(clk), .rst_n(rst_n), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
   .status_mfr(status_mfr), .status_vout(status_vout), .cml_clear(cml_clear),
   .conversion_enabled(conversion_enabled), .seq_ton_delay(seq_ton_delay),
   .seq_ton_rise(seq_ton_rise), .seq_toff_fall(seq_toff_fall), .seq_fault_stop(seq_fault_stop),
   .rd_data(rd_data), .rd_valid(rd_valid), .invalid_command_flag(invalid_command_flag),
   .cml_fault_flag(cml_fault_flag), .alert_req(alert_req), .power_good_out(power_good_out)
);

// >>> verif/status_pg_host.sv
// host model issuing register reads and writes
`timescale 1ns/1ps
module status_pg_host (
   input wire logic clk,
   output logic cmd_wr,
   output logic cmd_rd,
   output status_pg_pkg::cmd_type cmd_code,
   output status_pg_pkg::word_type cmd_wdata,
   input wire status_pg_pkg::snapshot_type rd_data,
   input wire logic rd_valid
);
   logic [55:0] got;
   initial begin
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
   end
   // one access, released after the taking edge; data is scrambled once released
   task automatic access(input logic w, input logic [7:0] c, input logic [15:0] d);
      @(negedge clk);
      cmd_wr = w;
      cmd_rd = !w;
      cmd_code = c;
      cmd_wdata = d;
      @(negedge clk);
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      cmd_wdata = ~d;
      got = (rd_valid === 1'b1) ? rd_data : {56{1'bx}};
   endtask : access
endmodule : status_pg_host

// >>> verif/status_phase_and_power_good_tb.sv
// self-checking bench for snapshot, phase summary and power good
`timescale 1ns/1ps
module status_phase_and_power_good_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cml_clear = 1'b0, conversion_enabled = 1'b0, pwm_tick = 1'b0;
   logic cmd_wr, cmd_rd, rd_valid, invalid_command_flag, cml_fault_flag, alert_req, power_good_out;
   logic [7:0] cmd_code, phase_sel = 8'hFF, pg_events = 8'h00, pg_event_continue = 8'h00;
   logic [15:0] cmd_wdata;
   logic [55:0] stat = 56'h00_0000_0000_0000, rd_data;
   logic [3:0] phase_fault_evt = 4'h0, phase_enabled = 4'hF, seq = 4'h0;
   logic [7:0] sels [6] = '{8'hFF, 8'h80, 8'h02, 8'h01, 8'hFF, 8'h02};
   logic [31:0] seed = 32'h0000_4190;
   int fails = 0, checks = 0, cyc = 0, n;
   always #4 clk = ~clk;
   status_pg_host u_host (.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid));
   status_phase_and_power_good u_status_phase_and_power_good (.clk(clk), .rst_n(rst_n),
      .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
      .phase_sel(phase_sel), .status_mfr(stat[55:48]), .status_other(stat[47:40]),
      .status_cml(stat[39:32]), .status_temp(stat[31:24]), .status_input(stat[23:16]),
      .status_iout(stat[15:8]), .status_vout(stat[7:0]), .cml_clear(cml_clear),
      .phase_fault_evt(phase_fault_evt), .phase_enabled(phase_enabled), .pg_events(pg_events),
      .pg_event_continue(pg_event_continue), .conversion_enabled(conversion_enabled),
      .seq_ton_delay(seq[0]), .seq_ton_rise(seq[1]), .seq_toff_fall(seq[2]),
      .seq_fault_stop(seq[3]), .pwm_tick(pwm_tick), .nvm_pg_config(16'h5A3C),
      .rd_data(rd_data), .rd_valid(rd_valid), .invalid_command_flag(invalid_command_flag),
      .cml_fault_flag(cml_fault_flag), .alert_req(alert_req), .power_good_out(power_good_out));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic int plen(input int k);
      return k == 0 ? 1 : (1 << k) + 1;
   endfunction : plen
   task automatic chk(input string nm, input logic [55:0] seen, input logic [55:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic tick(input int k);
      repeat (k) begin
         @(negedge clk);
         pwm_tick = 1'b1;
         @(negedge clk);
         pwm_tick = 1'b0;
         repeat (2) @(negedge clk);
      end
   endtask : tick
   task automatic ticks_until(input logic lv, output int k);
      k = 0;
      while (power_good_out !== lv && k < 70) begin
         tick(1);
         k++;
      end
   endtask : ticks_until
   task automatic report_and_stop();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         report_and_stop();
      end
   end
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      u_host.access(1'b0, 8'hE3, 16'h0000);
      chk("cfg_nvm", u_host.got, 56'h00_0000_0000_5A3C);
      for (int i = 0; i < 4; i++) begin
         repeat (2) begin
            seed = lfsr(seed);
            stat = {stat[23:0], seed};
         end
         u_host.access(i == 3, 8'hDB, seed[15:0]);
         if (i < 3) chk("snap", u_host.got, stat);
      end
      @(negedge clk);
      chk("ivc", {invalid_command_flag, cml_fault_flag, alert_req}, 3'b111);
      u_host.access(1'b0, 8'hDB, 16'h0000);
      chk("snap_kept", u_host.got, stat | 56'h00_0080_0000_0000);
      cml_clear = 1'b1;
      @(negedge clk);
      cml_clear = 1'b0;
      conversion_enabled = 1'b1;
      u_host.access(1'b1, 8'hE3, 16'h1234);
      u_host.access(1'b0, 8'hE3, 16'h0000);
      chk("cfg_lock", {alert_req, u_host.got[15:0]}, 17'h1_5A3C);
      phase_fault_evt = 4'b0101;
      @(negedge clk);
      phase_fault_evt = 4'h0;
      for (int i = 0; i < 6; i++) begin
         phase_enabled = i < 4 ? 4'hF : 4'hB;
         phase_sel = sels[i];
         n = phase_sel[7] ? (5 & phase_enabled) : ((5 & phase_enabled) >> phase_sel) & 1;
         u_host.access(1'b0, 8'hDC, 16'h0000);
         chk("phase", u_host.got, n);
      end
      phase_sel = 8'hFF;
      u_host.access(1'b1, 8'hDC, 16'h000F);
      u_host.access(1'b0, 8'hDC, 16'h0000);
      chk("phase_clr", u_host.got, 56'h00_0000_0000_0000);
      for (int i = 0; i < 8; i++) begin
         conversion_enabled = 1'b0;
         pg_events = 8'h00;
         // host only rewrites the config while disabled
         u_host.access(1'b1, 8'hE3, {4'(i % 4), 4'((i + 1) % 3), ~(8'h01 << i)});
         chk("pg_off", power_good_out, 1'b0);
         conversion_enabled = 1'b1;
         ticks_until(1'b1, n);
         pg_events = 8'h01 << ((i + 1) % 8);
         tick(12);
         chk("pg_mask", power_good_out, 1'b1);
         pg_events = 8'h01 << i;
         ticks_until(1'b0, n);
         chk("fall", n, plen(i % 4));
         pg_events = 8'h00;
         ticks_until(1'b1, n);
         chk("rise", n, plen((i + 1) % 3));
      end
      pg_event_continue = 8'h80;
      pg_events = 8'h80;
      tick(12);
      chk("pg_cont", power_good_out, 1'b1);
      pg_event_continue = 8'h00;
      tick(3);
      pg_events = 8'h00;
      tick(12);
      chk("pg_glitch", power_good_out, 1'b1);
      for (int k = 0; k < 4; k++) begin
         seq = 4'h1 << k;
         repeat (2) @(negedge clk);
         chk("pg_force", power_good_out, 1'b0);
         seq = 4'h0;
         ticks_until(1'b1, n);
      end
      report_and_stop();
   end
endmodule : status_phase_and_power_good_tb
